// ---- common/qsl_pkg.sv ----
// Purpose: Shared constants for the serial lane select and interrupt gate block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package qsl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SRC = 12;

  // Register byte offsets
  localparam logic [7:0] OFF_LANE_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SIG_ENABLE = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_LEVEL      = 8'h0C;
  localparam logic [7:0] OFF_FRAME      = 8'h10;

  // Lane control field positions
  localparam int unsigned CMD_LSB  = 0;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned MODE_LSB = 4;

  // Lane encodings
  localparam logic [1:0] LANES_SINGLE   = 2'h0;
  localparam logic [1:0] LANES_DUAL     = 2'h1;
  localparam logic [1:0] LANES_QUAD     = 2'h2;
  localparam logic [1:0] LANES_RESERVED = 2'h3;

  // Frame phase lengths in bits
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] MODE_BITS = 5'h08;

  // Event source bit positions
  localparam int unsigned SRC_TX_EMPTY   = 0;
  localparam int unsigned SRC_TX_FULL    = 1;
  localparam int unsigned SRC_TX_THR     = 2;
  localparam int unsigned SRC_RX_EMPTY   = 3;
  localparam int unsigned SRC_RX_FULL    = 4;
  localparam int unsigned SRC_RX_THR     = 5;
  localparam int unsigned SRC_CTRL_FULL  = 6;
  localparam int unsigned SRC_CTRL_EMPTY = 7;
  localparam int unsigned SRC_CTRL_THR   = 8;
  localparam int unsigned SRC_DESC_DONE  = 9;
  localparam int unsigned SRC_PKT_DONE   = 10;
  localparam int unsigned SRC_DMA_ERR    = 11;

  // Reset values
  localparam logic [5:0]  LANE_CTRL_RESET  = 6'h00;
  localparam logic [11:0] SIG_ENABLE_RESET = 12'h000;

endpackage

// ---- common/qsl_irq_if.sv ----
// Purpose: Carries event, enable and status between the top and the gate
// Assumes: Single clock domain
// Notes:   Clear is a write-one-to-clear pulse
`timescale 1ns/100ps
interface qsl_irq_if #(parameter int unsigned N = 12);
  logic [N-1:0] events;
  logic [N-1:0] enables;
  logic [N-1:0] clear;
  logic [N-1:0] status;
  logic         irq;
  modport top  (output events, output enables, output clear, input status, input irq);
  modport gate (input events, input enables, input clear, output status, output irq);
endinterface

// ---- logic/qsl_irq_gate.sv ----
// Purpose: Sticky event status and per-source enable gate onto one interrupt
// Assumes: Events are one-cycle pulses in the system clock domain
// Notes:   Status is tracked whatever the enables say
`timescale 1ns/100ps
module qsl_irq_gate
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  qsl_irq_if.gate   gate_if
);
  logic [gate_if.N-1:0] status;
  logic [gate_if.N-1:0] next_status;

  // Set wins over a simultaneous clear
  assign next_status = (status & ~gate_if.clear) | gate_if.events;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      status <= '0;
    else
      status <= next_status;

  assign gate_if.status = status;
  assign gate_if.irq    = |(status & gate_if.enables);

  gated_irq_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    gate_if.irq == |(status & gate_if.enables))
    else $error("interrupt does not match gated status");
  event_kept_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    gate_if.events[0] |=> status[0])
    else $error("event lost from status");

endmodule // qsl_irq_gate

// ---- logic/qsl_lane_sel.sv ----
// Purpose: Picks the lane count for the current phase of a boot read
// Assumes: Fields come from the lane control register
// Notes:   Reserved encoding falls back to a single lane
`timescale 1ns/100ps
module qsl_lane_sel
  import qsl_pkg::*;
(
  input  wire logic [1:0] field_in,
  output logic      [2:0] lanes_out
);
  assign lanes_out = (field_in == LANES_QUAD) ? 3'h4 :
                     (field_in == LANES_DUAL) ? 3'h2 : 3'h1;
endmodule // qsl_lane_sel

// ---- logic/qsl_top.sv ----
// Purpose: Lane width select and interrupt signal gate of a quad serial interface
// Assumes: APB slave on sys_clk_in; link clock sampled as a plain input
// Notes:   Phase lane counts follow the frame on the sampled link clock
//
// Overview of operation
// - Mode field bits 5:4 picks mode lanes
// - Address field bits 3:2 picks address lanes
// - Command field bits 1:0 picks command lanes
// - Bit 11 gates DMA bus error
// - Bit 10 gates packet done event
// - Bit 9 gates descriptor done event
// - Bits 8..6 gate control buffer events
// - Bits 5..3 gate receive buffer events
// - Bits 2..0 gate transmit buffer events
// - Bits 31:12 read zero; enables reset zero
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module qsl_top
  import qsl_pkg::*;
(
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [qsl_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [qsl_pkg::DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]                pstrb_in,
  output logic      [qsl_pkg::DATA_W-1:0] prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  input  wire logic [qsl_pkg::NUM_SRC-1:0] src_event_in,
  input  wire logic                      link_clk_in,
  input  wire logic                      link_cs_n_in,
  output logic      [1:0]                phase_out,
  output logic      [2:0]                lanes_out,
  output logic                           irq_out
);
  import qsl_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_MODE} phase_type;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic [5:0]         lane_ctrl;
  logic [NUM_SRC-1:0] sig_enable;
  wire                acc       = psel_in & penable_in;
  wire                wr        = acc & pwrite_in;
  wire                hit_lane  = (paddr_in == OFF_LANE_CTRL);
  wire                hit_en    = (paddr_in == OFF_SIG_ENABLE);
  wire                hit_stat  = (paddr_in == OFF_STATUS);
  wire                hit_lvl   = (paddr_in == OFF_LEVEL);
  wire                hit_frame = (paddr_in == OFF_FRAME);
  wire                mapped    = hit_lane | hit_en | hit_stat | hit_lvl | hit_frame;

  qsl_irq_if #(.N(NUM_SRC)) irq_bus ();

  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      lane_ctrl  <= LANE_CTRL_RESET;
      sig_enable <= SIG_ENABLE_RESET;
    end
    else
    begin
      if (wr && hit_lane && pstrb_in[0])
        lane_ctrl <= pwdata_in[5:0];
      if (wr && hit_en)
      begin
        if (pstrb_in[0])
          sig_enable[7:0] <= pwdata_in[7:0];
        if (pstrb_in[1])
          sig_enable[11:8] <= pwdata_in[11:8];
      end
    end

  // Write one to clear status; only lane 0 and 1 hold bits
  wire [NUM_SRC-1:0] clr_mask = {{4{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign irq_bus.clear   = (wr && hit_stat) ? (pwdata_in[NUM_SRC-1:0] & clr_mask)
                                            : '0;
  assign irq_bus.events  = src_event_in;
  assign irq_bus.enables = sig_enable;

  qsl_irq_gate u_gate
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .gate_if    (irq_bus)
  );

  assign irq_out = irq_bus.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock and select synchronisers
  logic [1:0] clk_sync;
  logic [1:0] cs_sync;
  logic       clk_prev;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      clk_sync <= 2'h0;
      cs_sync  <= 2'h3;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], link_clk_in};
      cs_sync  <= {cs_sync[0], link_cs_n_in};
      clk_prev <= clk_sync[1];
    end

  wire link_rise = clk_sync[1] & ~clk_prev;
  wire framing   = ~cs_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer: 8 command bits, 24 address bits, 8 mode bits
  phase_type  phase;
  phase_type  next_phase;
  logic [4:0] bits_left;
  logic [4:0] next_bits_left;
  logic [2:0] cur_lanes;
  logic [2:0] lanes_cmd;
  logic [2:0] lanes_addr;
  logic [2:0] lanes_mode;

  qsl_lane_sel u_sel_cmd (.field_in(lane_ctrl[CMD_LSB+:2]), .lanes_out(lanes_cmd));
  qsl_lane_sel u_sel_addr (.field_in(lane_ctrl[ADDR_LSB+:2]), .lanes_out(lanes_addr));
  qsl_lane_sel u_sel_mode (.field_in(lane_ctrl[MODE_LSB+:2]), .lanes_out(lanes_mode));

  assign cur_lanes = (phase == PH_ADDR) ? lanes_addr :
                     (phase == PH_MODE) ? lanes_mode : lanes_cmd;

  wire [4:0] step = {2'h0, cur_lanes};
  wire       last = (bits_left <= step);

  always_comb
  begin
    next_phase     = phase;
    next_bits_left = bits_left;
    case (phase)
      PH_IDLE:
        if (framing)
        begin
          next_phase     = PH_CMD;
          next_bits_left = CMD_BITS;
        end
      PH_CMD:
        if (link_rise && last)
        begin
          next_phase     = PH_ADDR;
          next_bits_left = ADDR_BITS;
        end
        else if (link_rise)
          next_bits_left = bits_left - step;
      PH_ADDR:
        if (link_rise && last)
        begin
          next_phase     = PH_MODE;
          next_bits_left = MODE_BITS;
        end
        else if (link_rise)
          next_bits_left = bits_left - step;
      PH_MODE:
        if (link_rise && !last)
          next_bits_left = bits_left - step;
      default:
        next_phase = PH_IDLE;
    endcase
    if (!framing)
      next_phase = PH_IDLE;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      phase     <= PH_IDLE;
      bits_left <= 5'h00;
      lanes_out <= 3'h1;
    end
    else
    begin
      phase     <= next_phase;
      bits_left <= next_bits_left;
      lanes_out <= cur_lanes;
    end

  assign phase_out = phase;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [DATA_W-1:0] rd_lane  = {26'h0, lane_ctrl};
  wire [DATA_W-1:0] rd_en    = {20'h0, sig_enable};
  wire [DATA_W-1:0] rd_stat  = {20'h0, irq_bus.status};
  wire [DATA_W-1:0] rd_lvl   = {31'h0, irq_out};
  wire [DATA_W-1:0] rd_frame = {27'h0, framing, lanes_out, 1'b0};

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      prdata_out <= '0;
    else if (psel_in && !penable_in && !pwrite_in)
      prdata_out <= hit_lane  ? rd_lane  :
                    hit_en    ? rd_en    :
                    hit_stat  ? rd_stat  :
                    hit_lvl   ? rd_lvl   :
                    hit_frame ? rd_frame : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence en_write_s;
    wr && hit_en && pstrb_in[1] && pwdata_in[SRC_DMA_ERR];
  endsequence

  sequence frame_open_s;
    phase == PH_IDLE && framing;
  endsequence

  dma_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     en_write_s |=> sig_enable[SRC_DMA_ERR])
    else $error("dma error gate not set");
  dma_block_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (irq_bus.status == (12'h1 << SRC_DMA_ERR) && !sig_enable[SRC_DMA_ERR]) |-> !irq_out)
    else $error("dma error passed while gated");
  pkt_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (irq_bus.status[SRC_PKT_DONE] && !sig_enable[SRC_PKT_DONE]
     && irq_bus.status[NUM_SRC-1:0] == (12'h1 << SRC_PKT_DONE)) |-> !irq_out)
    else $error("packet done passed while gated");
  pkt_pass_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (irq_bus.status[SRC_PKT_DONE] && sig_enable[SRC_PKT_DONE]) |-> irq_out)
    else $error("packet done not passed");
  desc_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (irq_bus.status[SRC_DESC_DONE] && sig_enable[SRC_DESC_DONE]) |-> irq_out)
    else $error("descriptor done not passed");
  desc_block_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (irq_bus.status == (12'h1 << SRC_DESC_DONE) && !sig_enable[SRC_DESC_DONE]) |-> !irq_out)
    else $error("descriptor done passed while gated");
  ctrl_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (|(irq_bus.status[8:6] & sig_enable[8:6])) |-> irq_out)
    else $error("control buffer event blocked");
  rcv_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (|(irq_bus.status[5:3] & sig_enable[5:3])) |-> irq_out)
    else $error("receive buffer event blocked");
  xmit_gate_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (|(irq_bus.status[2:0] & sig_enable[2:0])) |-> irq_out)
    else $error("transmit buffer event blocked");
  upper_zero_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && !pwrite_in && hit_en) |=> prdata_out[31:12] == 20'h0)
    else $error("unimplemented enable bits not zero");
  status_kept_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    src_event_in[SRC_TX_EMPTY] |=> irq_bus.status[SRC_TX_EMPTY])
    else $error("event not tracked in status");
  frame_open_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     frame_open_s |=> (phase == PH_CMD && bits_left == CMD_BITS))
    else $error("frame did not open with command phase");
  addr_lanes_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (phase == PH_ADDR && lane_ctrl[3:2] == LANES_QUAD) |=> lanes_out == 3'h4)
    else $error("address lanes wrong");
  addr_dual_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_ADDR && lane_ctrl[3:2] == LANES_DUAL) |=> lanes_out == 3'h2)
    else $error("dual address lanes wrong");
  addr_single_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_ADDR && lane_ctrl[3:2] == LANES_SINGLE) |=> lanes_out == 3'h1)
    else $error("single address lane wrong");
  cmd_lanes_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (phase == PH_CMD && lane_ctrl[1:0] == LANES_DUAL) |=> lanes_out == 3'h2)
    else $error("command lanes wrong");
  cmd_quad_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_CMD && lane_ctrl[1:0] == LANES_QUAD) |=> lanes_out == 3'h4)
    else $error("quad command lanes wrong");
  cmd_rsvd_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_CMD && lane_ctrl[1:0] == LANES_RESERVED) |=> lanes_out == 3'h1)
    else $error("reserved command code not single lane");
  mode_lanes_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (phase == PH_MODE && lane_ctrl[5:4] == LANES_SINGLE) |=> lanes_out == 3'h1)
    else $error("mode lanes wrong");
  mode_quad_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_MODE && lane_ctrl[5:4] == LANES_QUAD) |=> lanes_out == 3'h4)
    else $error("quad mode lanes wrong");
  mode_dual_a: assert property
    (@(posedge sys_clk_in) disable iff (!rst_n_in)
     (phase == PH_MODE && lane_ctrl[5:4] == LANES_DUAL) |=> lanes_out == 3'h2)
    else $error("dual mode lanes wrong");

endmodule // qsl_top

// ---- dv/qsl_flash_model.sv ----
// Purpose: Far-side serial flash that frames and clocks the link
// Assumes: Link clock period 80 ns, unrelated in phase to the system clock
// Notes:   Clock stands still low while the select is high
`timescale 1ns/100ps
module qsl_flash_model
(
  input  wire logic run_in,
  output logic      link_clk_out,
  output logic      link_cs_n_out
);
  initial
  begin
    link_clk_out  = 1'b0;
    link_cs_n_out = 1'b1;
    #3;
    forever
    begin
      #40;
      if (run_in && link_cs_n_out)
        link_cs_n_out = 1'b0;
      else if (run_in)
        link_clk_out = ~link_clk_out;
      else if (link_clk_out)
        link_clk_out = 1'b0;
      else
        link_cs_n_out = 1'b1;
    end
  end
endmodule // qsl_flash_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for lane select and interrupt gate
// Assumes: Zero-wait APB slave, link driven by the flash model
// Notes:   Byte strobes are held all ones
`timescale 1ns/100ps
module tb;
  import qsl_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, run, err;
  logic        link_clk, link_cs_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, bit_i;
  logic [11:0] src_event;
  logic [1:0]  phase, cmd, adr, mde;
  logic [2:0]  lanes;
  int          errors, checks_done, cycles;

  qsl_top dut
  (
    .sys_clk_in   (sys_clk),
    .rst_n_in     (rst_n),
    .psel_in      (psel),
    .penable_in   (penable),
    .pwrite_in    (pwrite),
    .paddr_in     (paddr),
    .pwdata_in    (pwdata),
    .pstrb_in     (4'hF),
    .prdata_out   (prdata),
    .pready_out   (pready),
    .pslverr_out  (pslverr),
    .src_event_in (src_event),
    .link_clk_in  (link_clk),
    .link_cs_n_in (link_cs_n),
    .phase_out    (phase),
    .lanes_out    (lanes),
    .irq_out      (irq)
  );

  qsl_flash_model flash
  (
    .run_in        (run),
    .link_clk_out  (link_clk),
    .link_cs_n_out (link_cs_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Counts: %0d mismatches, %0d checks", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk);
    src_event <= 12'h001 << i;
    @(posedge sys_clk);
    src_event <= 12'h000;
    #1;
  endtask

  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    while (phase !== p && n < 2000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("phase", {30'h0, phase}, {30'h0, p});
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] lanes_for(input logic [1:0] c);
    return (c == LANES_DUAL) ? 32'h2 : (c == LANES_QUAD) ? 32'h4 : 32'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, run} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_event = 12'h000;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_SIG_ENABLE, 32'h0);
    chk("enable reset", rd, 32'h0);
    apb(1'b1, OFF_SIG_ENABLE, 32'hFFFF_FFFF);
    apb(1'b0, OFF_SIG_ENABLE, 32'h0);
    chk("enable readback", rd, 32'h0000_0FFF);
    chk("no error", {31'h0, err}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < NUM_SRC; i++)
    begin
      bit_i = 32'h1 << i;
      apb(1'b1, OFF_SIG_ENABLE, 32'hFFF ^ bit_i);
      pulse(i);
      chk("irq gated off", {31'h0, irq}, 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status kept", rd, bit_i);
      apb(1'b1, OFF_SIG_ENABLE, bit_i);
      #1;
      chk("irq gated on", {31'h0, irq}, 32'h1);
      apb(1'b0, OFF_LEVEL, 32'h0);
      chk("irq level", rd, 32'h1);
      apb(1'b1, OFF_STATUS, bit_i);
      #1;
      chk("irq cleared", {31'h0, irq}, 32'h0);
      pulse(i);
      chk("irq next cycle", {31'h0, irq}, 32'h1);
      apb(1'b1, OFF_STATUS, bit_i);
    end
    for (int c = 0; c < 4; c++)
    begin
      mde = c[1:0];
      adr = mde + 2'h1;
      cmd = mde + 2'h2;
      apb(1'b1, OFF_LANE_CTRL, {26'h0, mde, adr, cmd});
      apb(1'b0, OFF_LANE_CTRL, 32'h0);
      chk("lane control", rd, {26'h0, mde, adr, cmd});
      @(posedge sys_clk);
      run <= 1'b1;
      wait_phase(2'h1);
      chk("command lanes", {29'h0, lanes}, lanes_for(cmd));
      wait_phase(2'h2);
      chk("address lanes", {29'h0, lanes}, lanes_for(adr));
      wait_phase(2'h3);
      chk("mode lanes", {29'h0, lanes}, lanes_for(mde));
      apb(1'b0, OFF_FRAME, 32'h0);
      chk("frame status", rd, 32'h10 | (lanes_for(mde) << 1));
      @(posedge sys_clk);
      run <= 1'b0;
      wait_phase(2'h0);
    end
    close_out();
  end
endmodule // tb
